// ==== src/bctc_timer.sv ====
// Eight-channel capture/compare timer with buffered captures and pulse accumulators
//
// The APB slave port and the register offsets were decided locally.
`default_nettype none
module bctc_timer
   import bctc_pkg::*;
(
   input  wire logic        clk_sys,    // Module clock, 50 MHz
   input  wire logic        rstn,       // Asynchronous reset, active low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB direction
   input  wire logic [7:0]  paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic      [31:0] prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB error
   input  wire logic [7:0]  timer_pin_in,  // Timer port pin levels
   output logic      [7:0]  timer_pin_out, // Timer port drive values
   output logic      [7:0]  timer_pin_oe,  // Timer port output enables
   output logic             modcount_zero  // Modulus counter zero pulse
);
   import bctc_pkg::*;

   // ----------------------------------------------------------------
   // State and edge detection
   // ----------------------------------------------------------------
   bctc_state_s st_reg;    // Registered state
   bctc_state_s st_next;   // Next state
   logic [7:0]  edge_ok;   // Valid capture transition per channel
   logic [7:0]  pin_rise;  // Rising edge per pin
   logic [7:0]  pin_fall;  // Falling edge per pin

   // Per-channel edge qualification
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_edge
         assign pin_rise[g] = timer_pin_in[g] & ~st_reg.pin_prev[g];
         assign pin_fall[g] = ~timer_pin_in[g] & st_reg.pin_prev[g];
         // 00 off, 01 rising, 10 falling, 11 both
         assign edge_ok[g]  = (st_reg.edge_lo[g] & pin_rise[g]) | (st_reg.edge_hi[g] & pin_fall[g]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   // Returns read data and whether the address is mapped
   function automatic logic [32:0] read_mux(input bctc_state_s s, input logic [7:0] a, input logic [7:0] pin);
      logic [31:0] d;
      logic        ok;
      d  = '0;
      ok = 1'b1;
      case (a)
         BCTC_OFS_DIR_SEL:   d[7:0]  = s.dir_sel;
         BCTC_OFS_FORCE:     d[7:0]  = BCTC_RESET_BYTE;
         BCTC_OFS_MASK7:     d[7:0]  = s.mask7;
         BCTC_OFS_DATA7:     d[7:0]  = s.data7;
         // Inputs show pin level, outputs show driver level
         BCTC_OFS_PORT_DATA: d[7:0]  = (s.pin_oe & s.pin_out) | (~s.pin_oe & pin);
         BCTC_OFS_PORT_DIR:  d[7:0]  = s.port_dir;
         BCTC_OFS_OUT_MODE:  d[15:0] = {s.ol, s.om};
         BCTC_OFS_EDGE_SEL:  d[15:0] = {s.edge_hi, s.edge_lo};
         BCTC_OFS_CAP_CTRL:  d[10:0] = {s.pair, s.sat, s.latch_queue_select, s.novw};
         BCTC_OFS_MC_CTRL:   d[5:0]  = {s.mc_psc, s.mc_per, s.mc_en};
         BCTC_OFS_MC_COUNT:  d[15:0] = s.mc_cnt;
         BCTC_OFS_MAIN_CNT:  d[15:0] = s.main_cnt;
         default:
         begin
            ok = 1'b0;
            for (int n = 0; n < 8; n++)
            begin
               if (a == BCTC_OFS_CHAN_BASE + 8'(4 * n))
               begin
                  d[15:0] = s.chan_val[n];
                  ok      = 1'b1;
               end
            end
            for (int k = 0; k < 4; k++)
            begin
               if (a == BCTC_OFS_HOLD_BASE + 8'(4 * k))
               begin
                  d[15:0] = s.hold_val[k];
                  ok      = 1'b1;
               end
               if (a == BCTC_OFS_ACC_BASE + 8'(4 * k))
               begin
                  d[7:0] = s.acc[k];
                  ok     = 1'b1;
               end
               if (a == BCTC_OFS_ACCH_BASE + 8'(4 * k))
               begin
                  d[7:0] = s.acc_hold[k];
                  ok     = 1'b1;
               end
            end
         end
      endcase
      return {ok, d};
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Bus, modulus counter, captures, accumulators, compares, pins
   always_comb
   begin
      logic        acc_done;   // Access phase completes this edge
      logic        wr;         // Write completes
      logic        rd;         // Read completes
      logic        latch_ev;   // Holding latch event
      logic        mc_tick;    // Prescaler tick
      logic [32:0] rmux;       // Read mux result
      logic [7:0]  force_bits; // Forced compare channels
      logic [7:0]  cmp_ev;     // Compare actions this cycle
      logic [7:0]  own;        // Pins owned by compare logic
      logic [3:0]  inc;        // Accumulator increment
      logic [1:0]  act;        // Mode/level pair
      acc_done   = psel & penable & st_reg.pready;
      wr         = acc_done & pwrite;
      rd         = acc_done & ~pwrite;
      latch_ev   = 1'b0;
      mc_tick    = 1'b0;
      force_bits = '0;
      cmp_ev     = '0;
      own        = '0;
      inc        = '0;
      act        = '0;
      rmux       = read_mux(st_reg, paddr, timer_pin_in);
      st_next    = st_reg;
      st_next.mc_zero  = 1'b0;
      st_next.pin_prev = timer_pin_in;
      st_next.main_cnt = 16'(st_reg.main_cnt + BCTC_ONE16);

      // APB: one wait cycle, then the access completes
      if (psel && penable && !st_reg.pready)
      begin
         st_next.pready  = 1'b1;
         st_next.prdata  = rmux[31:0];
         st_next.pslverr = ~rmux[32];
      end
      else
      begin
         st_next.pready  = 1'b0;
         st_next.pslverr = 1'b0;
      end

      // Register writes, whole words only
      if (wr && rmux[32])
      begin
         case (paddr)
            BCTC_OFS_DIR_SEL:   st_next.dir_sel   = pwdata[7:0];
            BCTC_OFS_FORCE:     force_bits        = pwdata[7:0];
            BCTC_OFS_MASK7:     st_next.mask7     = pwdata[7:0];
            BCTC_OFS_DATA7:     st_next.data7     = pwdata[7:0];
            BCTC_OFS_PORT_DATA: st_next.port_data = pwdata[7:0];
            BCTC_OFS_PORT_DIR:  st_next.port_dir  = pwdata[7:0];
            BCTC_OFS_OUT_MODE:
            begin
               st_next.om = pwdata[7:0];
               st_next.ol = pwdata[15:8];
            end
            BCTC_OFS_EDGE_SEL:
            begin
               st_next.edge_lo = pwdata[7:0];
               st_next.edge_hi = pwdata[15:8];
            end
            BCTC_OFS_CAP_CTRL:
            begin
               st_next.novw = pwdata[BCTC_CAP_NOVW_LSB +: 8];
               st_next.latch_queue_select = pwdata[BCTC_CAP_LATCH_QUEUE_SELECT_BIT];
               st_next.sat  = pwdata[BCTC_CAP_SAT_BIT];
               st_next.pair = pwdata[BCTC_CAP_PAIR_BIT];
            end
            BCTC_OFS_MC_CTRL:
            begin
               st_next.mc_en  = pwdata[BCTC_MC_EN_BIT];
               st_next.mc_per = pwdata[BCTC_MC_PER_BIT];
               st_next.mc_psc = pwdata[BCTC_MC_PSC_LSB +: 4];
               latch_ev       = pwdata[BCTC_MC_FLAT_BIT];
            end
            BCTC_OFS_MC_COUNT:
            begin
               // Full 16-bit load in one access
               st_next.mc_load = pwdata[15:0];
               st_next.mc_cnt  = pwdata[15:0];
               st_next.mc_pcnt = '0;
               if (pwdata[15:0] == BCTC_RESET_WORD)
               begin
                  latch_ev = 1'b1;
               end
            end
            default:
            begin
               for (int n = 0; n < 8; n++)
               begin
                  if (paddr == BCTC_OFS_CHAN_BASE + 8'(4 * n))
                  begin
                     st_next.chan_val[n] = pwdata[15:0];
                  end
               end
            end
         endcase
      end

      // Reads empty capture and holding registers
      if (rd)
      begin
         for (int n = 0; n < 8; n++)
         begin
            if (paddr == BCTC_OFS_CHAN_BASE + 8'(4 * n))
            begin
               st_next.cap_full[n] = 1'b0;
            end
         end
         for (int k = 0; k < 4; k++)
         begin
            if (paddr == BCTC_OFS_HOLD_BASE + 8'(4 * k))
            begin
               st_next.hold_full[k] = 1'b0;
               if (!st_reg.latch_queue_select)
               begin
                  st_next.acc_hold[k] = st_reg.acc[k];
                  st_next.acc[k]      = BCTC_RESET_BYTE;
               end
            end
         end
      end

      // Modulus down-counter with prescaler
      if (st_reg.mc_en && !(wr && paddr == BCTC_OFS_MC_COUNT))
      begin
         if (st_reg.mc_pcnt == st_reg.mc_psc)
         begin
            mc_tick         = 1'b1;
            st_next.mc_pcnt = '0;
         end
         else
         begin
            st_next.mc_pcnt = 4'(st_reg.mc_pcnt + 4'h1);
         end
         if (mc_tick && st_reg.mc_cnt != BCTC_RESET_WORD)
         begin
            st_next.mc_cnt = 16'(st_reg.mc_cnt - BCTC_ONE16);
            if (st_reg.mc_cnt == BCTC_ONE16)
            begin
               latch_ev        = 1'b1;
               st_next.mc_zero = 1'b1;
               // Periodic reloads, one-shot stays at zero
               if (st_reg.mc_per)
               begin
                  st_next.mc_cnt = st_reg.mc_load;
               end
            end
         end
      end

      // Latch mode: move captures and accumulators to holding
      if (latch_ev && st_reg.latch_queue_select)
      begin
         for (int k = 0; k < 4; k++)
         begin
            if (!st_reg.novw[k] || !st_reg.hold_full[k])
            begin
               st_next.hold_val[k]  = st_reg.chan_val[k];
               st_next.hold_full[k] = st_reg.cap_full[k];
               st_next.cap_full[k]  = 1'b0;
            end
            st_next.acc_hold[k] = st_next.acc[k];
            st_next.acc[k]      = BCTC_RESET_BYTE;
         end
      end

      // Captures on input channels
      for (int n = 0; n < 8; n++)
      begin
         if (edge_ok[n] && !st_reg.dir_sel[n])
         begin
            if (n < 4 && !st_reg.latch_queue_select)
            begin
               // Queue: shift old capture, then store
               if (!st_reg.novw[n])
               begin
                  st_next.hold_val[n]  = st_reg.chan_val[n];
                  st_next.hold_full[n] = st_reg.cap_full[n];
                  st_next.chan_val[n]  = st_reg.main_cnt;
                  st_next.cap_full[n]  = 1'b1;
               end
               else if (!st_next.cap_full[n])
               begin
                  st_next.chan_val[n] = st_reg.main_cnt;
                  st_next.cap_full[n] = 1'b1;
               end
               else if (!st_next.hold_full[n])
               begin
                  st_next.hold_val[n]  = st_reg.chan_val[n];
                  st_next.hold_full[n] = 1'b1;
                  st_next.chan_val[n]  = st_reg.main_cnt;
               end
            end
            else if (!st_reg.novw[n] || !st_next.cap_full[n])
            begin
               st_next.chan_val[n] = st_reg.main_cnt;
               st_next.cap_full[n] = 1'b1;
            end
         end
      end

      // Pulse accumulators on the buffered channels
      for (int k = 0; k < 4; k++)
      begin
         inc[k] = edge_ok[k];
      end
      for (int k = 0; k < 4; k++)
      begin
         // Odd accumulator of a pair counts carries: even one just wrapped to zero
         if (st_reg.pair && k[0])
         begin
            inc[k] = inc[k - 1] && st_next.acc[k - 1] == BCTC_RESET_BYTE;
         end
         if (inc[k])
         begin
            if (st_reg.sat && !st_reg.pair && st_next.acc[k] == BCTC_ACC_MAX)
            begin
               st_next.acc[k] = BCTC_ACC_MAX;
            end
            else
            begin
               st_next.acc[k] = 8'(st_next.acc[k] + BCTC_ONE8);
            end
         end
      end

      // Compare matches and forced actions
      for (int n = 0; n < 8; n++)
      begin
         cmp_ev[n] = st_reg.dir_sel[n] & ((st_reg.chan_val[n] == st_reg.main_cnt) | force_bits[n]);
      end
      for (int n = 0; n < 8; n++)
      begin
         act = {st_reg.om[n], st_reg.ol[n]};
         if (cmp_ev[7] && st_reg.mask7[n])
         begin
            st_next.oc_level[n] = st_reg.data7[n];
         end
         else if (cmp_ev[n] && !st_reg.mask7[n])
         begin
            case (act)
               2'b01:   st_next.oc_level[n] = ~st_reg.oc_level[n];
               2'b10:   st_next.oc_level[n] = 1'b0;
               2'b11:   st_next.oc_level[n] = 1'b1;
               default: st_next.oc_level[n] = st_reg.oc_level[n];
            endcase
         end
      end

      // Pin ownership and drive
      own            = st_reg.dir_sel & (st_reg.om | st_reg.ol | st_reg.mask7);
      st_next.pin_oe = own | st_next.port_dir;
      for (int n = 0; n < 8; n++)
      begin
         st_next.pin_out[n] = own[n] ? st_next.oc_level[n] : st_next.port_data[n];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // All state clears on reset
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign prdata        = st_reg.prdata;
   assign pready        = st_reg.pready;
   assign pslverr       = st_reg.pslverr;
   assign timer_pin_out = st_reg.pin_out;
   assign timer_pin_oe  = st_reg.pin_oe;
   assign modcount_zero = st_reg.mc_zero;

endmodule
`default_nettype wire

// ==== src/bctc_pkg.sv ====
// Package for the buffered capture timer channels: register map, fields and state layout
`default_nettype none
package bctc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets (APB, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] BCTC_OFS_DIR_SEL   = 8'h00; // Channel direction select
   localparam logic [7:0] BCTC_OFS_FORCE     = 8'h04; // Compare force, reads zero
   localparam logic [7:0] BCTC_OFS_MASK7     = 8'h08; // Channel-7 port mask
   localparam logic [7:0] BCTC_OFS_DATA7     = 8'h0C; // Channel-7 port data
   localparam logic [7:0] BCTC_OFS_PORT_DATA = 8'h10; // Timer port data latch
   localparam logic [7:0] BCTC_OFS_PORT_DIR  = 8'h14; // Timer port direction
   localparam logic [7:0] BCTC_OFS_OUT_MODE  = 8'h18; // [7:0] mode, [15:8] level
   localparam logic [7:0] BCTC_OFS_EDGE_SEL  = 8'h1C; // [7:0] low bits, [15:8] high bits
   localparam logic [7:0] BCTC_OFS_CAP_CTRL  = 8'h20; // Capture system control
   localparam logic [7:0] BCTC_OFS_MC_CTRL   = 8'h24; // Modulus counter control
   localparam logic [7:0] BCTC_OFS_MC_COUNT  = 8'h28; // Modulus counter load / value
   localparam logic [7:0] BCTC_OFS_MAIN_CNT  = 8'h2C; // Main counter, read only
   localparam logic [7:0] BCTC_OFS_CHAN_BASE = 8'h30; // Channel values 0..7
   localparam logic [7:0] BCTC_OFS_HOLD_BASE = 8'h50; // Capture holding 0..3
   localparam logic [7:0] BCTC_OFS_ACC_BASE  = 8'h60; // Accumulators 0..3
   localparam logic [7:0] BCTC_OFS_ACCH_BASE = 8'h70; // Accumulator holding 0..3

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BCTC_CAP_NOVW_LSB = 0;  // No-overwrite bits [7:0]
   localparam int BCTC_CAP_LATCH_QUEUE_SELECT_BIT = 8;  // 1 latch mode, 0 queue mode
   localparam int BCTC_CAP_SAT_BIT  = 9;  // Accumulator saturate
   localparam int BCTC_CAP_PAIR_BIT = 10; // Cascade accumulator pairs
   localparam int BCTC_MC_EN_BIT    = 0;  // Modulus counter enable
   localparam int BCTC_MC_PER_BIT   = 1;  // 1 periodic, 0 one-shot
   localparam int BCTC_MC_PSC_LSB   = 2;  // Prescaler [5:2]
   localparam int BCTC_MC_FLAT_BIT  = 8;  // Force latch, write-one pulse

   // ----------------------------------------------------------------
   // Reset and fixed values
   // ----------------------------------------------------------------
   localparam logic [7:0]  BCTC_RESET_BYTE  = 8'h00; // All byte registers
   localparam logic [15:0] BCTC_RESET_WORD  = 16'h0000; // All word registers
   localparam logic [7:0]  BCTC_ACC_MAX     = 8'hFF; // Saturation value
   localparam logic [15:0] BCTC_ONE16       = 16'h0001;
   localparam logic [7:0]  BCTC_ONE8        = 8'h01;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]       dir_sel;   // 1 = output compare
      logic [7:0]       mask7;     // Channel-7 port mask
      logic [7:0]       data7;     // Channel-7 port data
      logic [7:0]       port_data; // Port data latch
      logic [7:0]       port_dir;  // Port direction
      logic [7:0]       om;        // Compare output mode
      logic [7:0]       ol;        // Compare output level
      logic [7:0]       edge_lo;   // Edge select low bits
      logic [7:0]       edge_hi;   // Edge select high bits
      logic [7:0]       novw;      // No-overwrite bits
      logic             latch_queue_select;      // Latch/queue select
      logic             sat;       // Accumulator saturate
      logic             pair;      // 16-bit accumulator pairs
      logic             mc_en;     // Modulus counter running
      logic             mc_per;    // Periodic reload
      logic [3:0]       mc_psc;    // Prescaler setting
      logic [3:0]       mc_pcnt;   // Prescaler count
      logic [15:0]      mc_load;   // Reload value
      logic [15:0]      mc_cnt;    // Current value
      logic             mc_zero;   // Zero pulse
      logic [15:0]      main_cnt;  // Main up-counter
      logic [7:0][15:0] chan_val;  // Capture / compare values
      logic [7:0]       cap_full;  // Capture register holds data
      logic [3:0][15:0] hold_val;  // Capture holding registers
      logic [3:0]       hold_full; // Holding register holds data
      logic [3:0][7:0]  acc;       // Pulse accumulators
      logic [3:0][7:0]  acc_hold;  // Accumulator holding
      logic [7:0]       pin_prev;  // Previous pin sample
      logic [7:0]       oc_level;  // Compare output levels
      logic [7:0]       pin_out;   // Pin drive value
      logic [7:0]       pin_oe;    // Pin output enable
      logic             pready;    // APB ready
      logic             pslverr;   // APB error
      logic [31:0]      prdata;    // APB read data
   } bctc_state_s;

endpackage
`default_nettype wire

// ==== tb/bctc_timer_checker.sv ====
// Checker for bus timing and pin-side relations of the capture timer
`default_nettype none
module bctc_timer_checker
   import bctc_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  timer_pin_in,
   input wire logic [7:0]  timer_pin_out,
   input wire logic [7:0]  timer_pin_oe,
   input wire logic        modcount_zero
);
   import bctc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // Bus answer timing and read data
   // ----------------------------------------------------------------
   a_no_early_ready: assert property (psel && !penable |-> !pready ##1 !pready)
      else $error("answer came before the wait state");
   a_ready_after_wait: assert property (psel && penable && !pready |=> pready)
      else $error("answer missing after one wait");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready stood too long");
   a_error_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer carried data");
   a_force_reads_zero: assert property (pready && !pwrite && paddr == BCTC_OFS_FORCE
      |-> prdata == 32'h0000_0000)
      else $error("force register read nonzero");
   a_upper_half_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   // ----------------------------------------------------------------
   // Pin ownership and modulus counter
   // ----------------------------------------------------------------
   a_oe_by_write: assert property ($changed(timer_pin_oe) |-> $past(pready) || $past(pready, 2))
      else $error("enable moved without a write");
   a_zero_single: assert property (modcount_zero |=> !modcount_zero)
      else $error("zero pulse too long");
   // Main scenarios reached
   c_read: cover property (pready && !pwrite);
   c_error: cover property (pslverr);
   c_zero: cover property (modcount_zero);
endmodule
bind bctc_timer bctc_timer_checker chk_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_pin_in(timer_pin_in),
   .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .modcount_zero(modcount_zero));
`default_nettype wire

// ==== tb/bctc_pin_model.sv ====
// Model of the timer port pins seen from outside
`default_nettype none
module bctc_pin_model
(
   input  wire logic [7:0] drive,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   output logic      [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Driven pins show the block's level, others the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule
`default_nettype wire

// ==== tb/test_bctc_timer.sv ====
// Self-checking bench for the capture timer
`default_nettype none
module test_bctc_timer;
   timeunit 1ns;
   timeprecision 1ns;
   import bctc_pkg::*;
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, mz, rerr;
   logic [7:0]  paddr, drive, pin_in, pin_out, pin_oe;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] cv;
   int          fails, checks, cyc, ts, t1, t2, zc;
   bctc_timer dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_pin_in(pin_in), .timer_pin_out(pin_out),
      .timer_pin_oe(pin_oe), .modcount_zero(mz));
   bctc_pin_model pins_u (.drive(drive), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   // Clock and cycle count
   initial
   begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (mz === 1'b1) zc <= zc + 1;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One APB transfer, bounded wait on ready
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 40);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40)
      begin
         fails++;
         test_done();
      end
   endtask
   // One pin pulse, stamp of its rise
   task pulse(input logic [7:0] m);
      @(posedge clk_sys);
      drive <= drive | m;
      ts = cyc;
      @(posedge clk_sys);
      drive <= drive & ~m;
   endtask
   task settle();
      repeat (3) @(posedge clk_sys);
   endtask
   task rd_pair();
      bus(0, BCTC_OFS_CHAN_BASE, 32'h0);
      cv = rdat[15:0];
      bus(0, BCTC_OFS_HOLD_BASE, 32'h0);
      cv = cv - rdat[15:0];
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs();
      bus(1, BCTC_OFS_DIR_SEL, 32'h0000_00A5);
      bus(0, BCTC_OFS_DIR_SEL, 32'h0);
      chk(rdat, 32'h0000_00A5);
      bus(0, BCTC_OFS_FORCE, 32'h0);
      chk(rdat, 32'h0);
      bus(0, 8'hFC, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      bus(1, BCTC_OFS_DIR_SEL, 32'h0);
      $display("register test done");
   endtask
   task t_queue();
      bus(1, BCTC_OFS_EDGE_SEL, 32'h0000_0603);
      pulse(8'h01);
      t1 = ts;
      repeat (3) pulse(8'h00);
      pulse(8'h01);
      t2 = ts;
      settle();
      rd_pair();
      chk({16'h0, cv}, 32'(16'(t2 - t1)));
      bus(0, BCTC_OFS_ACCH_BASE, 32'h0);
      chk(rdat, 32'h2);
      bus(0, BCTC_OFS_ACC_BASE, 32'h0);
      chk(rdat, 32'h0);
      $display("queue test done");
   endtask
   task t_latch();
      bus(1, BCTC_OFS_CAP_CTRL, 32'h0000_0101);
      pulse(8'h01);
      t1 = ts;
      pulse(8'h01);
      bus(1, BCTC_OFS_MC_COUNT, 32'h0);
      pulse(8'h01);
      settle();
      rd_pair();
      chk({16'h0, cv}, 32'(16'(ts - t1)));
      bus(0, BCTC_OFS_ACCH_BASE, 32'h0);
      chk(rdat, 32'h2);
      bus(0, BCTC_OFS_ACC_BASE, 32'h0);
      chk(rdat, 32'h1);
      $display("latch test done");
   endtask
   task t_sat();
      bus(1, BCTC_OFS_CAP_CTRL, 32'h0000_0200);
      repeat (150) pulse(8'h0E);
      settle();
      bus(0, BCTC_OFS_ACC_BASE + 8'h04, 32'h0);
      chk(rdat, 32'h0000_00FF);
      bus(0, BCTC_OFS_ACC_BASE + 8'h08, 32'h0);
      chk(rdat, 32'h0000_0096);
      bus(0, BCTC_OFS_ACC_BASE + 8'h0C, 32'h0);
      chk(rdat, 32'h0);
      $display("saturate test done");
   endtask
   task t_pair();
      bus(1, BCTC_OFS_CAP_CTRL, 32'h0000_0500);
      bus(1, BCTC_OFS_MC_COUNT, 32'h0);
      repeat (255) pulse(8'h01);
      settle();
      bus(0, BCTC_OFS_ACC_BASE + 8'h04, 32'h0);
      chk(rdat, 32'h0);
      pulse(8'h01);
      settle();
      bus(0, BCTC_OFS_ACC_BASE + 8'h04, 32'h0);
      chk(rdat, 32'h1);
      bus(0, BCTC_OFS_ACC_BASE, 32'h0);
      chk(rdat, 32'h0);
      $display("pair test done");
   endtask
   task t_compare();
      bus(1, BCTC_OFS_DIR_SEL, 32'h0000_0081);
      bus(1, BCTC_OFS_OUT_MODE, 32'h0000_0101);
      bus(1, BCTC_OFS_FORCE, 32'h0000_0001);
      settle();
      chk({24'h0, pin_oe & 8'h01}, 32'h1);
      chk({24'h0, pin_out & 8'h01}, 32'h1);
      bus(1, BCTC_OFS_OUT_MODE, 32'h0000_0001);
      bus(1, BCTC_OFS_MASK7, 32'h0000_0001);
      bus(1, BCTC_OFS_FORCE, 32'h0000_0001);
      settle();
      chk({24'h0, pin_out & 8'h01}, 32'h1);
      bus(1, BCTC_OFS_FORCE, 32'h0000_0080);
      bus(1, BCTC_OFS_OUT_MODE, 32'h0);
      bus(1, BCTC_OFS_PORT_DATA, 32'h0000_0001);
      settle();
      chk({24'h0, pin_out & 8'h01}, 32'h0);
      chk({24'h0, pin_oe & 8'h01}, 32'h1);
      bus(1, BCTC_OFS_MASK7, 32'h0);
      bus(1, BCTC_OFS_PORT_DIR, 32'h0000_0001);
      settle();
      chk({24'h0, pin_out & 8'h01}, 32'h1);
      $display("compare test done");
   endtask
   task t_mod();
      bus(1, BCTC_OFS_MC_COUNT, 32'h0000_0004);
      bus(1, BCTC_OFS_MC_CTRL, 32'h0000_0003);
      repeat (10) @(posedge clk_sys);
      t1 = zc;
      repeat (40) @(posedge clk_sys);
      chk(32'(zc - t1), 32'h0000_000A);
      bus(1, BCTC_OFS_MC_CTRL, 32'h0000_0001);
      bus(1, BCTC_OFS_MC_COUNT, 32'h0000_0004);
      @(posedge clk_sys);
      t1 = zc;
      repeat (40) @(posedge clk_sys);
      chk(32'(zc - t1), 32'h1);
      $display("modulus test done");
   endtask
   // Main sequence
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata, drive} = '0;
      {fails, checks, cyc, zc} = '0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_queue();
      t_latch();
      t_sat();
      t_pair();
      t_compare();
      t_mod();
      test_done();
   end
endmodule
`default_nettype wire
